// *** shared/alarm_pkg.sv ***
// alarm codes, attributes, timing and state types for the servo alarm manager
// assumes a single system clock; table order is also the capture priority
package alarm_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int MCLK_HZ = 10000000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = MCLK_HZ / MS_PER_S;
    localparam int OVERLOAD_HOLD_S = 10;
    localparam int OVERLOAD_HOLD_MS = OVERLOAD_HOLD_S * MS_PER_S;
    localparam int STOP_LIMIT_MAX_MS = 1000;
    localparam int STOP_LIMIT_W = 10;
    localparam int MS_W = 14;
    localparam int CYC_W = 14;

    // ------------------------------------------------------------
    // alarm table, index = detector input bit, lower index wins
    // ------------------------------------------------------------
    localparam int N_ALARM = 23;
    localparam int IDX_W = 5;
    localparam int IDX_OVERLOAD = 6;
    localparam int IDX_ENC_LOSS = 8;
    localparam int IDX_POS_DEV = 11;
    localparam int IDX_OVERSPEED = 13;
    localparam int IDX_OVERSPEED2 = 14;
    localparam int IDX_PULSE_MULT = 16;
    localparam int IDX_DEV_OVF = 17;
    localparam int IDX_PARAM = 18;
    localparam int IDX_TRAVEL = 19;
    localparam int IDX_ABS_DOWN = 20;
    localparam int IDX_ABS_OVERSPEED = 21;
    localparam int IDX_FORCED = 22;

    // main codes held as two bcd digits
    localparam logic [7:0] MAIN_BCD [N_ALARM] = '{
        8'h11, 8'h12, 8'h13, 8'h14, 8'h14, 8'h15, 8'h16, 8'h18,
        8'h21, 8'h21, 8'h23, 8'h24, 8'h24, 8'h26, 8'h26, 8'h27,
        8'h27, 8'h29, 8'h36, 8'h38, 8'h40, 8'h42, 8'h87};
    localparam logic [3:0] SUB_CODE [N_ALARM] = '{
        4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0,
        4'h0, 4'h1, 4'h0, 4'h0, 4'h1, 4'h0, 4'h1, 4'h0,
        4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};

    // attribute bits
    localparam int ATTR_HIST = 0;
    localparam int ATTR_CLR = 1;
    localparam int ATTR_IMM = 2;
    localparam logic [2:0] ATTR [N_ALARM] = '{
        3'h2, 3'h3, 3'h2, 3'h1, 3'h1, 3'h5, 3'h3, 3'h5,
        3'h1, 3'h1, 3'h1, 3'h7, 3'h7, 3'h7, 3'h3, 3'h7,
        3'h7, 3'h3, 3'h0, 3'h2, 3'h3, 3'h3, 3'h2};

    // ------------------------------------------------------------
    // stop sequence and display
    // ------------------------------------------------------------
    localparam logic [2:0] STOP_SEL_MIN = 3'h4;
    localparam int N_DIGIT = 3;
    localparam logic [6:0] SEG_BLANK = 7'h00;
    localparam logic [6:0] SEG7 [16] = '{
        7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
        7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};

    typedef enum logic [1:0] {ST_NORMAL, ST_FAST_STOP, ST_TRIP} state_t;

endpackage

// *** shared/alarm_code_if.sv ***
// lookup request and answer between the alarm manager and its code table
// purely combinational; no clock travels here
`timescale 1ns/1ns
`default_nettype none
interface alarm_code_if;
    logic [alarm_pkg::IDX_W-1:0] idx;
    logic [1:0] param_cause;
    logic [7:0] main_bcd;
    logic [3:0] sub_code;
    logic hist;
    logic clr;
    logic imm;
    modport table_side (input idx, input param_cause,
                        output main_bcd, output sub_code, output hist, output clr, output imm);
    modport user_side (output idx, output param_cause,
                       input main_bcd, input sub_code, input hist, input clr, input imm);
endinterface
`default_nettype wire

// *** core/alarm_code_table.sv ***
// fixed per-alarm code and attribute lookup
// assumes idx below alarm_pkg::N_ALARM
`timescale 1ns/1ns
`default_nettype none
module alarm_code_table (
    // lookup port
    alarm_code_if.table_side look
);
    wire [2:0] attr = alarm_pkg::ATTR[look.idx];
    wire is_param = look.idx == alarm_pkg::IDX_W'(alarm_pkg::IDX_PARAM);

    assign look.main_bcd = alarm_pkg::MAIN_BCD[look.idx];
    // storage faults carry their cause as sub code
    assign look.sub_code = is_param ? {2'h0, look.param_cause} : alarm_pkg::SUB_CODE[look.idx];
    assign look.hist = attr[alarm_pkg::ATTR_HIST];
    assign look.clr = attr[alarm_pkg::ATTR_CLR];
    assign look.imm = attr[alarm_pkg::ATTR_IMM];
endmodule
`default_nettype wire

// *** core/servo_alarm_manager.sv ***
// servo drive alarm manager: capture, trip, fast stop, clear and display
// assumes detector and clear inputs synchronous to mclk_in
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - any protective detection drops the fault output, latches a trip and shows the code on the 7-segment digits.
// - position deviation excess is 24.0 and velocity deviation excess is 24.1, both immediate-stop alarms.
// - command pulse frequency fault is 27.0 and pulse multiplier fault is 27.2, both immediate-stop alarms.
// - a clear of the overload alarm is refused until about ten seconds after it was raised.
// - the absolute system down and absolute overspeed alarms survive clears until the absolute encoder is cleared.
// - a clearable alarm may be cleared by the clear input, the front panel or the communication port.
// - fast shutdown happens only for immediate-stop alarms and only with stop sequence select 4 to 7.
// - encoder link loss is 21.0, link fault is 21.1 and encoder data faults are 23.
// - deviation counter overflow is 29.0 and is not an immediate-stop alarm.
// - parameter storage faults are code 36 with sub code 0 to 3 for the cause, without immediate stop.
// - the forced-alarm input raises 87.0.
// - the over-travel inhibit input raises 38 without immediate stop.
// - a stop time limit of zero skips the fast stop and trips at once; the limit spans 0 to 1000 ms.
// - with both overspeed alarms together the first is shown but no fast shutdown is made.
module servo_alarm_manager #(
    parameter int CYCLES_PER_MS = alarm_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // fault detectors, one level per table entry
    input wire logic [alarm_pkg::N_ALARM-1:0] fault_det_in,
    input wire logic [1:0] param_cause_in,
    // stop configuration and motion state
    input wire logic [2:0] stop_sequence_select_in,
    input wire logic [alarm_pkg::STOP_LIMIT_W-1:0] stop_time_limit_in,
    input wire logic stop_done_in,
    // clear paths
    input wire logic fault_clear_input_in,
    input wire logic panel_clear_in,
    input wire logic comm_clear_in,
    input wire logic abs_encoder_clear_in,
    // alarm state
    output logic fault_output_out,
    output logic trip_out,
    output logic fast_stop_out,
    output logic [7:0] main_code_out,
    output logic [3:0] sub_code_out,
    output logic hist_attr_out,
    output logic clr_attr_out,
    output logic imm_attr_out,
    output logic history_write_out,
    output logic clear_reject_out,
    // display, digit 0 main tens, 1 main units, 2 sub
    output logic [6:0] seg_out [alarm_pkg::N_DIGIT]
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    alarm_pkg::state_t state_q, state_d;
    logic [alarm_pkg::IDX_W-1:0] idx_q;
    logic [7:0] main_q;
    logic [3:0] sub_q;
    logic hist_q, clr_q, imm_q;
    logic hist_wr_q, reject_q;
    logic clr_in_q;
    logic abs_clr_q, abs_clr_d;
    logic [alarm_pkg::CYC_W-1:0] cyc_q, cyc_d;
    logic [alarm_pkg::MS_W-1:0] ms_q, ms_d;
    logic [6:0] seg_q [alarm_pkg::N_DIGIT];
    logic [alarm_pkg::IDX_W-1:0] cap_idx;
    logic [alarm_pkg::N_ALARM-1:0] imm_mask;

    alarm_code_if look ();

    alarm_code_table u_table (
        .look(look.table_side)
    );

    // ------------------------------------------------------------
    // capture and lookup
    // ------------------------------------------------------------
    // lowest index wins, so 26.0 shows over 26.1
    always_comb begin
        cap_idx = '0;
        for (int i = alarm_pkg::N_ALARM - 1; i >= 0; i--) begin
            if (fault_det_in[i]) begin
                cap_idx = alarm_pkg::IDX_W'(i);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < alarm_pkg::N_ALARM; g++) begin : g_mask
            assign imm_mask[g] = alarm_pkg::ATTR[g][alarm_pkg::ATTR_IMM];
        end
    endgenerate

    assign look.idx = cap_idx;
    assign look.param_cause = param_cause_in;

    wire any_det = |fault_det_in;
    wire capture = (state_q == alarm_pkg::ST_NORMAL) && any_det;
    // a live non-stop alarm, such as 26.1, vetoes the fast stop
    wire any_non_imm = |(fault_det_in & ~imm_mask);
    wire sel_ok = stop_sequence_select_in >= alarm_pkg::STOP_SEL_MIN;
    wire limit_zero = stop_time_limit_in == '0;
    wire fast_ok = look.imm && sel_ok && !limit_zero && !any_non_imm;

    // ------------------------------------------------------------
    // millisecond timer since capture
    // ------------------------------------------------------------
    localparam logic [alarm_pkg::MS_W-1:0] HOLD_MS = alarm_pkg::MS_W'(alarm_pkg::OVERLOAD_HOLD_MS);
    wire tick = cyc_q == alarm_pkg::CYC_W'(CYCLES_PER_MS - 1);
    wire ms_sat = ms_q == HOLD_MS;
    assign cyc_d = (capture || tick) ? '0 : cyc_q + 1'b1;
    // saturates at the overload hold, which is longer than any stop limit
    assign ms_d = capture ? '0 : (tick && !ms_sat) ? ms_q + 1'b1 : ms_q;
    wire stop_expired = ms_q >= {4'h0, stop_time_limit_in};

    // ------------------------------------------------------------
    // clear decision
    // ------------------------------------------------------------
    wire clr_rise = fault_clear_input_in && !clr_in_q;
    wire clr_req = clr_rise || panel_clear_in || comm_clear_in;
    wire is_overload = idx_q == alarm_pkg::IDX_W'(alarm_pkg::IDX_OVERLOAD);
    wire is_abs = (idx_q == alarm_pkg::IDX_W'(alarm_pkg::IDX_ABS_DOWN)) ||
                  (idx_q == alarm_pkg::IDX_W'(alarm_pkg::IDX_ABS_OVERSPEED));
    wire hold_ok = !is_overload || (ms_q >= HOLD_MS);
    wire abs_ok = !is_abs || abs_clr_q;
    wire clr_ok = (state_q == alarm_pkg::ST_TRIP) && clr_q && hold_ok && abs_ok;
    wire clear_accept = clr_req && clr_ok;
    wire clear_refuse = clr_req && (state_q != alarm_pkg::ST_NORMAL) && !clr_ok;
    // encoder clear counts only while an alarm stands and is forgotten at the next capture
    assign abs_clr_d = capture ? 1'b0 :
                       (abs_encoder_clear_in && state_q != alarm_pkg::ST_NORMAL) ? 1'b1 : abs_clr_q;

    // ------------------------------------------------------------
    // trip sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            alarm_pkg::ST_NORMAL: begin
                if (capture) begin
                    state_d = fast_ok ? alarm_pkg::ST_FAST_STOP : alarm_pkg::ST_TRIP;
                end
            end
            alarm_pkg::ST_FAST_STOP: begin
                // a non-stop alarm during the stop ends it at once
                if (stop_done_in || stop_expired || any_non_imm) begin
                    state_d = alarm_pkg::ST_TRIP;
                end
            end
            alarm_pkg::ST_TRIP: begin
                if (clear_accept) begin
                    state_d = alarm_pkg::ST_NORMAL;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= alarm_pkg::ST_NORMAL;
            cyc_q <= '0;
            ms_q <= '0;
            clr_in_q <= 1'b0;
            abs_clr_q <= 1'b0;
            hist_wr_q <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cyc_q <= cyc_d;
            ms_q <= ms_d;
            clr_in_q <= fault_clear_input_in;
            abs_clr_q <= abs_clr_d;
            hist_wr_q <= capture && look.hist;
            reject_q <= clear_refuse;
        end
    end

    // the code stays latched after a clear; only the display blanks
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            idx_q <= '0;
            main_q <= '0;
            sub_q <= '0;
            {hist_q, clr_q, imm_q} <= 3'h0;
        end else if (capture) begin
            idx_q <= cap_idx;
            main_q <= look.main_bcd;
            sub_q <= look.sub_code;
            {hist_q, clr_q, imm_q} <= {look.hist, look.clr, look.imm};
        end
    end

    // ------------------------------------------------------------
    // display
    // ------------------------------------------------------------
    wire alarmed = state_q != alarm_pkg::ST_NORMAL;
    wire [3:0] digit [alarm_pkg::N_DIGIT];
    assign digit[0] = main_q[7:4];
    assign digit[1] = main_q[3:0];
    assign digit[2] = sub_q;

    generate
        for (g = 0; g < alarm_pkg::N_DIGIT; g++) begin : g_seg
            always_ff @(posedge mclk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    seg_q[g] <= alarm_pkg::SEG_BLANK;
                end else begin
                    seg_q[g] <= alarmed ? alarm_pkg::SEG7[digit[g]] : alarm_pkg::SEG_BLANK;
                end
            end
            assign seg_out[g] = seg_q[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign fault_output_out = !alarmed;
    assign trip_out = state_q == alarm_pkg::ST_TRIP;
    assign fast_stop_out = state_q == alarm_pkg::ST_FAST_STOP;
    assign main_code_out = main_q;
    assign sub_code_out = sub_q;
    assign hist_attr_out = hist_q;
    assign clr_attr_out = clr_q;
    assign imm_attr_out = imm_q;
    assign history_write_out = hist_wr_q;
    assign clear_reject_out = reject_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    trip_drops_out_a: assert property (capture |=> !fault_output_out && main_code_out != 8'h00)
        else $error("capture did not drop the fault output");
    pos_dev_code_a: assert property (capture && cap_idx == 5'h0b |=> main_code_out == 8'h24 &&
        sub_code_out == 4'h0 && imm_attr_out)
        else $error("position deviation code wrong");
    pulse_mult_code_a: assert property (capture && cap_idx == 5'h10 |=> main_code_out == 8'h27 &&
        sub_code_out == 4'h2 && imm_attr_out)
        else $error("pulse multiplier code wrong");
    overload_hold_a: assert property (trip_out && is_overload && ms_q < HOLD_MS && clr_req |=>
        trip_out && clear_reject_out)
        else $error("overload cleared too early");
    abs_hold_a: assert property (trip_out && is_abs && !abs_clr_q && clr_req |=> trip_out[*2])
        else $error("absolute alarm cleared without encoder clear");
    panel_clear_a: assert property (trip_out && clr_q && !is_abs && !is_overload && panel_clear_in |=>
        fault_output_out)
        else $error("panel clear not taken");
    no_fast_sel_a: assert property (capture && stop_sequence_select_in < 3'h4 |=> !fast_stop_out)
        else $error("fast stop with low stop selection");
    enc_loss_code_a: assert property (capture && cap_idx == 5'h08 |=> main_code_out == 8'h21 &&
        sub_code_out == 4'h0)
        else $error("encoder loss code wrong");
    dev_ovf_a: assert property (capture && cap_idx == 5'h11 |=> main_code_out == 8'h29 && !imm_attr_out &&
        !fast_stop_out)
        else $error("deviation overflow handled as stop alarm");
    param_code_a: assert property (capture && cap_idx == 5'h12 |=> main_code_out == 8'h36 &&
        sub_code_out == {2'h0, $past(param_cause_in)} && !imm_attr_out)
        else $error("storage fault code wrong");
    forced_code_a: assert property (capture && cap_idx == 5'h16 |=> main_code_out == 8'h87)
        else $error("forced alarm code wrong");
    travel_code_a: assert property (capture && cap_idx == 5'h13 |=> main_code_out == 8'h38 &&
        !imm_attr_out)
        else $error("over-travel code wrong");
    zero_limit_a: assert property (capture && stop_time_limit_in == 10'h000 |=> trip_out)
        else $error("zero stop limit did not trip at once");
    dual_os_a: assert property (capture && fault_det_in[13] && fault_det_in[14] |=>
        main_code_out == 8'h26 && sub_code_out == 4'h0 && !fast_stop_out)
        else $error("dual overspeed handled wrongly");
    attr_table_a: assert property (capture |=> clr_attr_out == $past(look.clr) &&
        hist_attr_out == $past(look.hist))
        else $error("attributes not latched from table");

    fast_stop_seen_c: cover property (capture && fast_ok ##1 fast_stop_out ##[1:20] trip_out);
    clear_cycle_c: cover property (trip_out && clear_accept ##1 fault_output_out);
    refuse_seen_c: cover property (clear_reject_out);
    abs_release_c: cover property (trip_out && is_abs && abs_clr_q && clr_req);

endmodule
`default_nettype wire

// *** verification/host_ctrl_model.sv ***
// host controller model: watches the fault output and drives the edge-based clear input
// assumes the bench pulses clear_req_in for one cycle and reports motor standstill
`timescale 1ns/1ns
`default_nettype none
module host_ctrl_model (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // drive status
    input wire logic fault_output_in,
    input wire logic stopped_in,
    input wire logic clear_req_in,
    // clear line
    output logic fault_clear_out
);
    // ------------------------------------------------------------
    // clear pulse
    // ------------------------------------------------------------
    logic [1:0] hold_q;
    // clear only while alarmed and stopped; a held level gives a single rising edge
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hold_q <= 2'h0;
        end else if (clear_req_in && !fault_output_in && stopped_in) begin
            hold_q <= 2'h2;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
    end
    assign fault_clear_out = (hold_q != 2'h0);
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the servo alarm manager
// assumes a 10 MHz clock and a shortened millisecond tick of 4 cycles
`timescale 1ns/1ns
`default_nettype none
module tb;
    // ------------------------------------------------------------
    // stimulus and wiring
    // ------------------------------------------------------------
    localparam int CPM = 4;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [22:0] det = 23'h0;
    logic [1:0] cause = 2'h0;
    logic [2:0] sel = 3'h0;
    logic [9:0] lim = 10'h0;
    logic stop_done = 1'b0, panel = 1'b0, comm = 1'b0, abs_clr = 1'b0, host_req = 1'b0;
    wire logic fclr, fault_out, trip, fast, hist, clra, imm, hwr, rej;
    wire logic [7:0] main_code;
    wire logic [3:0] sub_code;
    logic [6:0] seg [3];
    int n_errors = 0;
    int total_checks = 0;
    always #50 mclk_in = ~mclk_in;
    host_ctrl_model host (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .fault_output_in(fault_out),
        .stopped_in(stop_done), .clear_req_in(host_req), .fault_clear_out(fclr));
    servo_alarm_manager #(.CYCLES_PER_MS(CPM)) dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .fault_det_in(det), .param_cause_in(cause), .stop_sequence_select_in(sel),
        .stop_time_limit_in(lim), .stop_done_in(stop_done), .fault_clear_input_in(fclr),
        .panel_clear_in(panel), .comm_clear_in(comm), .abs_encoder_clear_in(abs_clr),
        .fault_output_out(fault_out), .trip_out(trip), .fast_stop_out(fast), .main_code_out(main_code),
        .sub_code_out(sub_code), .hist_attr_out(hist), .clr_attr_out(clra), .imm_attr_out(imm),
        .history_write_out(hwr), .clear_reject_out(rej), .seg_out(seg));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic restart();
        det = 23'h0;
        rst_b_in = 1'b0;
        tick(2);
        rst_b_in = 1'b1;
        tick(1);
    endtask
    // clears are one-cycle pulses; the host path answers within a few cycles
    task automatic pulse_clear(input int src);
        if (src == 0) host_req = 1'b1;
        if (src == 1) panel = 1'b1;
        if (src == 2) comm = 1'b1;
        tick(1);
        host_req = 1'b0;
        panel = 1'b0;
        comm = 1'b0;
    endtask
    task automatic wait_healthy();
        for (int i = 0; i < 10 && fault_out !== 1'b1; i++) tick(1);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    localparam int CI [11] = '{8, 9, 10, 11, 12, 15, 16, 17, 18, 19, 22};
    localparam logic [7:0] CM [11] = '{8'h21, 8'h21, 8'h23, 8'h24, 8'h24, 8'h27, 8'h27, 8'h29,
        8'h36, 8'h38, 8'h87};
    localparam logic [3:0] CS [11] = '{4'h0, 4'h1, 4'h0, 4'h0, 4'h1, 4'h0, 4'h2, 4'h0, 4'h2, 4'h0, 4'h0};
    // 2 means the immediate-stop attribute is left open for that entry
    localparam logic [1:0] CIMM [11] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2};
    task automatic codes_test();
        for (int k = 0; k < 11; k++) begin
            restart();
            sel = 3'h4;
            lim = 10'h005;
            cause = 2'h2;
            det[CI[k]] = 1'b1;
            tick(1);
            chk("fault_output", 8'h00, {7'h0, fault_out});
            chk("main_code", CM[k], main_code);
            chk("sub_code", {4'h0, CS[k]}, {4'h0, sub_code});
            if (CIMM[k] != 2'h2) chk("imm_attr", {7'h0, CIMM[k][0]}, {7'h0, imm});
            if (CIMM[k] == 2'h0) chk("trip", 8'h01, {7'h0, trip});
            tick(1);
            chk("seg_tens", {1'b0, alarm_pkg::SEG7[CM[k][7:4]]}, {1'b0, seg[0]});
            chk("seg_units", {1'b0, alarm_pkg::SEG7[CM[k][3:0]]}, {1'b0, seg[1]});
            chk("seg_sub", {1'b0, alarm_pkg::SEG7[CS[k]]}, {1'b0, seg[2]});
        end
    endtask
    task automatic select_test();
        for (int s = 0; s < 8; s++) begin
            restart();
            sel = s[2:0];
            lim = 10'h005;
            det[11] = 1'b1;
            tick(1);
            chk("fast_stop", {7'h0, s >= 4}, {7'h0, fast});
            chk("history_write", 8'h01, {7'h0, hwr});
            if (s == 4) begin
                stop_done = 1'b1;
                tick(2);
                chk("trip_done", 8'h01, {7'h0, trip});
                stop_done = 1'b0;
            end
            if (s == 7) begin
                tick(15);
                chk("fast_hold", 8'h01, {7'h0, fast});
                tick(10);
                chk("trip_limit", 8'h01, {7'h0, trip});
            end
        end
    endtask
    task automatic zero_and_overspeed_test();
        restart();
        sel = 3'h4;
        lim = 10'h000;
        det[11] = 1'b1;
        tick(1);
        chk("zero_limit_fast", 8'h00, {7'h0, fast});
        chk("zero_limit_trip", 8'h01, {7'h0, trip});
        restart();
        lim = 10'h005;
        det[13] = 1'b1;
        det[14] = 1'b1;
        tick(1);
        chk("overspeed_main", 8'h26, main_code);
        chk("overspeed_sub", 8'h00, {4'h0, sub_code});
        chk("overspeed_fast", 8'h00, {7'h0, fast});
    endtask
    task automatic sources_test();
        restart();
        sel = 3'h0;
        stop_done = 1'b1;
        for (int src = 0; src < 3; src++) begin
            det[17] = 1'b1;
            tick(1);
            det[17] = 1'b0;
            tick(2);
            pulse_clear(src);
            wait_healthy();
            chk("cleared_out", 8'h01, {7'h0, fault_out});
            chk("cleared_trip", 8'h00, {7'h0, trip});
            tick(1);
            chk("seg_blank", 8'h00, {1'b0, seg[0]});
        end
        stop_done = 1'b0;
    endtask
    task automatic overload_test();
        restart();
        sel = 3'h0;
        det[6] = 1'b1;
        tick(1);
        det[6] = 1'b0;
        tick(2);
        pulse_clear(1);
        chk("overload_reject", 8'h01, {7'h0, rej});
        chk("overload_trip", 8'h01, {7'h0, trip});
        // the hold is ten seconds of shortened ms ticks
        tick(alarm_pkg::OVERLOAD_HOLD_MS * CPM);
        pulse_clear(2);
        wait_healthy();
        chk("overload_cleared", 8'h01, {7'h0, fault_out});
    endtask
    task automatic absolute_test();
        for (int e = 20; e < 22; e++) begin
            restart();
            det[e] = 1'b1;
            tick(1);
            det[e] = 1'b0;
            tick(2);
            pulse_clear(1);
            chk("abs_reject", 8'h01, {7'h0, rej});
            chk("abs_trip", 8'h01, {7'h0, trip});
            abs_clr = 1'b1;
            tick(1);
            abs_clr = 1'b0;
            pulse_clear(2);
            wait_healthy();
            chk("abs_cleared", 8'h01, {7'h0, fault_out});
        end
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        tick(10);
        rst_b_in = 1'b1;
        tick(1);
        codes_test();
        select_test();
        zero_and_overspeed_test();
        sources_test();
        overload_test();
        absolute_test();
        print_verdict();
    end
    initial begin
        #(60000 * 100);
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
